// >>> hdl/dac_ctrl_irq_status_regs.sv
// Operation
// [RULE_01] six write-only enables, sync/mu/receiver lost and locked, reset zero
// [RULE_02] enable 0 blocks updates and clears the matching status bit
// [RULE_03] read-only status mirrors enable positions, resets to zero
// [RULE_04] locked bit reads 1 while controller locked, 0 after lock lost
// [RULE_05] lost bit reads 1 once controller unlocked, else 0
// [RULE_06] software rearms status by writing enable 0 then 1
// [RULE_07] ten-bit full-scale code split low byte and high two bits
// [RULE_08] bit 7 of high full-scale register puts output to sleep
// [RULE_09] two-bit output mode: baseband, return-to-zero, mix
// [RULE_10] clock-phase bit 2: data clock edge before early phase-0 edge
// [RULE_11] clock-phase bit 0: data clock edge before late phase-0 edge
// [RULE_12] sync-phase bit 5: sync input edge before phase-90 edge
// [RULE_13] sync-phase bit 4: sync input edge before phase-0 edge
// [RULE_14] write-only bit 7 clears sync controller flags, written 1 then 0
// [RULE_15] write-only bit 2 clears receiver controller flags, written 1 then 0
// [RULE_16] sync loop bit resets 1, relock and interrupt for master
// [RULE_17] bit 5 selects sync role, slave at reset
// [RULE_18] bit 4 enables sync controller, disabled at reset
// [RULE_19] receiver loop bit resets 1, interrupt and automatic relock
// [RULE_20] bit 0 enables receiver controller, disabled at reset
// [RULE_21] software reset bit holds all other registers at defaults
// [RULE_22] interrupt output is the OR of the six status bits
module dac_ctrl_irq_status_regs (
  input  wire logic                          sys_clk,        // system clock
  input  wire logic                          resetn,         // sync reset, active low
  input  wire logic                          spi_cs_n,       // port select, active low
  input  wire logic                          spi_sclk,       // serial clock pin
  input  wire logic                          spi_sdi,        // serial data in
  output logic                               spi_sdo,        // serial data out
  output logic                               spi_sdo_oe,     // serial out enable
  input  wire conv_regs_pkg::lock_cond_type  lock_cond,      // controller lock levels
  input  wire conv_regs_pkg::phase_cond_type phase_cond,     // phase detector levels
  output logic [9:0]                         full_scale_code, // output current code
  output logic                               sleep,          // output disable
  output conv_regs_pkg::output_mode_type     output_mode,    // switch mode
  output conv_regs_pkg::ctrl_cfg_type        ctrl_cfg,       // controller controls
  output logic                               irq             // pending interrupt
);

  // ************************************************
  // serial port
  // ************************************************
  logic        sclk_d_r;
  logic [4:0]  bit_cnt_r;
  logic [14:0] shift_r;
  logic [7:0]  rd_shift_r;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        wr_en;
  logic        rd_load;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [6:0]  rd_addr;

  assign sclk_rise = spi_sclk & ~sclk_d_r & ~spi_cs_n;
  assign sclk_fall = ~spi_sclk & sclk_d_r & ~spi_cs_n;
  assign wr_en     = sclk_rise & (bit_cnt_r == conv_regs_pkg::CNT_FRAME_LAST) & ~shift_r[14];
  assign wr_addr   = shift_r[13:7];
  assign wr_data   = {shift_r[6:0], spi_sdi};
  assign rd_load   = sclk_rise & (bit_cnt_r == conv_regs_pkg::CNT_INSTR_LAST) & shift_r[6];
  assign rd_addr   = {shift_r[5:0], spi_sdi};

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= spi_sclk;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || spi_cs_n) begin
      bit_cnt_r <= 5'h00;
      shift_r   <= 15'h0000;
    end else if (sclk_rise) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      shift_r   <= {shift_r[13:0], spi_sdi};
    end
  end

  // ************************************************
  // register state
  // ************************************************
  logic [7:0]    port_cfg_r;
  logic [5:0]    irq_en_r;
  logic [5:0]    status_r;
  logic [5:0]    status_nxt;
  logic [7:0]    fs_low_r;
  logic [7:0]    fs_high_r;
  logic [1:0]    mode_r;
  logic [7:0]    rx_cfg_r;
  logic [7:0]    clk_phase_r;
  logic [7:0]    sync_phase_r;
  logic          soft_rst;

  assign soft_rst = port_cfg_r[conv_regs_pkg::BIT_SOFT_RESET];

  function automatic logic wr_hit(input logic en, input logic [6:0] a, input logic [6:0] ref_a);
    wr_hit = en & (a == ref_a);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      port_cfg_r <= conv_regs_pkg::RST_PORT_CFG;
    end else if (wr_hit(wr_en, wr_addr, conv_regs_pkg::ADDR_PORT_CFG)) begin
      port_cfg_r <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst) begin // [RULE_21]
      irq_en_r <= conv_regs_pkg::RST_IRQ_EN; // [RULE_01]
    end else if (wr_hit(wr_en, wr_addr, conv_regs_pkg::ADDR_IRQ_ENABLE)) begin
      irq_en_r <= wr_data[5:0]; // [RULE_01]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst) begin // [RULE_21]
      fs_low_r  <= conv_regs_pkg::RST_FS_LOW; // [RULE_07]
      fs_high_r <= conv_regs_pkg::RST_FS_HIGH; // [RULE_07]
      mode_r    <= conv_regs_pkg::RST_MODE; // [RULE_09]
    end else begin
      if (wr_hit(wr_en, wr_addr, conv_regs_pkg::ADDR_FS_LOW)) begin
        fs_low_r <= wr_data; // [RULE_07]
      end
      if (wr_hit(wr_en, wr_addr, conv_regs_pkg::ADDR_FS_HIGH)) begin
        fs_high_r <= wr_data & conv_regs_pkg::WR_MASK_FS_HIGH; // [RULE_07] [RULE_08]
      end
      if (wr_hit(wr_en, wr_addr, conv_regs_pkg::ADDR_MODE_SEL)) begin
        mode_r <= wr_data[1:0]; // [RULE_09]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst) begin // [RULE_21]
      rx_cfg_r <= conv_regs_pkg::RST_RX_CFG; // [RULE_16] [RULE_17] [RULE_18] [RULE_19] [RULE_20]
    end else if (wr_hit(wr_en, wr_addr, conv_regs_pkg::ADDR_RX_CFG)) begin
      rx_cfg_r <= wr_data & conv_regs_pkg::WR_MASK_RX_CFG; // [RULE_14] [RULE_15]
    end
  end

  // lost bits hold once set; locked bits follow the lock level
  always_comb begin
    status_nxt = (status_r & conv_regs_pkg::LOST_MASK) | lock_cond; // [RULE_05]
    status_nxt = (status_nxt & conv_regs_pkg::LOST_MASK)
               | (lock_cond & ~conv_regs_pkg::LOST_MASK); // [RULE_04]
    status_nxt = status_nxt & irq_en_r; // [RULE_02] [RULE_03] [RULE_06]
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst) begin // [RULE_21]
      status_r <= conv_regs_pkg::RST_STATUS; // [RULE_03]
      irq      <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |status_nxt; // [RULE_22]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst) begin // [RULE_21]
      clk_phase_r  <= conv_regs_pkg::RST_PHASE;
      sync_phase_r <= conv_regs_pkg::RST_PHASE;
    end else begin
      clk_phase_r  <= conv_regs_pkg::RST_PHASE;
      sync_phase_r <= conv_regs_pkg::RST_PHASE;
      clk_phase_r[conv_regs_pkg::BIT_EARLY_PH0]  <= phase_cond.early_edge_phase0_status; // [RULE_10]
      clk_phase_r[conv_regs_pkg::BIT_LATE_PH0]   <= phase_cond.late_edge_phase0_status; // [RULE_11]
      sync_phase_r[conv_regs_pkg::BIT_SYNC_PH90] <= phase_cond.sync_input_phase90_status; // [RULE_12]
      sync_phase_r[conv_regs_pkg::BIT_SYNC_PH0]  <= phase_cond.sync_input_phase0_status; // [RULE_13]
    end
  end

  // ************************************************
  // outputs to the converter and controllers
  // ************************************************
  assign full_scale_code = {fs_high_r[1:0], fs_low_r}; // [RULE_07]
  assign sleep           = fs_high_r[conv_regs_pkg::BIT_SLEEP]; // [RULE_08]
  assign output_mode     = conv_regs_pkg::output_mode_type'(mode_r); // [RULE_09]
  assign ctrl_cfg.sync_flag_clear            = rx_cfg_r[conv_regs_pkg::BIT_SYNC_FLG_CLR]; // [RULE_14]
  assign ctrl_cfg.sync_auto_relock           = rx_cfg_r[conv_regs_pkg::BIT_SYNC_LOOP]; // [RULE_16]
  assign ctrl_cfg.sync_role_select           = rx_cfg_r[conv_regs_pkg::BIT_SYNC_ROLE]; // [RULE_17]
  assign ctrl_cfg.sync_controller_enable     = rx_cfg_r[conv_regs_pkg::BIT_SYNC_ENA]; // [RULE_18]
  assign ctrl_cfg.receiver_flag_clear        = rx_cfg_r[conv_regs_pkg::BIT_RX_FLG_CLR]; // [RULE_15]
  assign ctrl_cfg.receiver_auto_relock       = rx_cfg_r[conv_regs_pkg::BIT_RX_LOOP]; // [RULE_19]
  assign ctrl_cfg.receiver_controller_enable = rx_cfg_r[conv_regs_pkg::BIT_RX_ENA]; // [RULE_20]

  // ************************************************
  // read path
  // ************************************************
  function automatic logic [7:0] read_mux(input logic [6:0] a);
    unique case (a)
      conv_regs_pkg::ADDR_PORT_CFG:   read_mux = port_cfg_r;
      conv_regs_pkg::ADDR_IRQ_STATUS: read_mux = {2'b00, status_r}; // [RULE_03]
      conv_regs_pkg::ADDR_FS_LOW:     read_mux = fs_low_r;
      conv_regs_pkg::ADDR_FS_HIGH:    read_mux = fs_high_r;
      conv_regs_pkg::ADDR_MODE_SEL:   read_mux = {6'h00, mode_r};
      conv_regs_pkg::ADDR_CLK_PHASE:  read_mux = clk_phase_r;
      conv_regs_pkg::ADDR_SYNC_PHASE: read_mux = sync_phase_r;
      conv_regs_pkg::ADDR_RX_CFG:     read_mux = rx_cfg_r & conv_regs_pkg::RD_MASK_RX_CFG; // [RULE_14] [RULE_15]
      default:                        read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!resetn || spi_cs_n) begin
      rd_shift_r <= 8'h00;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (rd_load) begin
      rd_shift_r <= read_mux(rd_addr);
      spi_sdo_oe <= 1'b1;
    end else if (sclk_fall) begin
      spi_sdo    <= rd_shift_r[7];
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end
  end

  // ************************************************
  // checks
  // ************************************************
  sequence s_write(logic [6:0] a);
    wr_en && !soft_rst && (wr_addr == a);
  endsequence

  property p_en_clears;
    @(posedge sys_clk) disable iff (!resetn)
      s_write(conv_regs_pkg::ADDR_IRQ_ENABLE) |=> ##1
        ((status_r & ~$past(wr_data[5:0], 2)) == 6'h00);
  endproperty
  a_en_clears: assert property (p_en_clears) else $error("status set while disabled"); // [RULE_02]

  property p_locked_follows;
    @(posedge sys_clk) disable iff (!resetn)
      (irq_en_r[0] && lock_cond.receiver_locked && !soft_rst) |=> status_r[0];
  endproperty
  a_locked_follows: assert property (p_locked_follows) else $error("locked bit missed"); // [RULE_04]

  property p_lost_sticky;
    @(posedge sys_clk) disable iff (!resetn)
      (status_r[1] && irq_en_r[1] && !soft_rst) |=> status_r[1];
  endproperty
  a_lost_sticky: assert property (p_lost_sticky) else $error("lost bit dropped"); // [RULE_05]

  property p_fs_write;
    @(posedge sys_clk) disable iff (!resetn)
      s_write(conv_regs_pkg::ADDR_FS_LOW) |=> (full_scale_code[7:0] == $past(wr_data));
  endproperty
  a_fs_write: assert property (p_fs_write) else $error("full-scale low not stored"); // [RULE_07]

  property p_sleep_write;
    @(posedge sys_clk) disable iff (!resetn)
      s_write(conv_regs_pkg::ADDR_FS_HIGH) |=> (sleep == $past(wr_data[7]));
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("sleep not stored"); // [RULE_08]

  property p_soft_reset;
    @(posedge sys_clk) disable iff (!resetn)
      soft_rst |=> (full_scale_code == 10'h200) && !sleep && (status_r == 6'h00)
                   && ctrl_cfg.sync_auto_relock && !ctrl_cfg.sync_controller_enable;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state"); // [RULE_21]

  property p_irq_or;
    @(posedge sys_clk) disable iff (!resetn)
      ((|(6'(lock_cond) & irq_en_r)) && !soft_rst) |=> irq && (irq == (|status_r));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of status"); // [RULE_22]

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!resetn)
      s_write(conv_regs_pkg::ADDR_RX_CFG) |=>
        (ctrl_cfg.sync_flag_clear == $past(wr_data[7]))
        && (ctrl_cfg.receiver_flag_clear == $past(wr_data[2]));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear not driven"); // [RULE_14]

  property p_phase_status;
    @(posedge sys_clk) disable iff (!resetn)
      !soft_rst |=>
        (clk_phase_r[conv_regs_pkg::BIT_EARLY_PH0] == $past(phase_cond.early_edge_phase0_status))
        && (sync_phase_r[conv_regs_pkg::BIT_SYNC_PH0] == $past(phase_cond.sync_input_phase0_status));
  endproperty
  a_phase_status: assert property (p_phase_status) else $error("phase status stale"); // [RULE_10]

  property p_late_status;
    @(posedge sys_clk) disable iff (!resetn)
      !soft_rst |=>
        (clk_phase_r[conv_regs_pkg::BIT_LATE_PH0] == $past(phase_cond.late_edge_phase0_status))
        && (sync_phase_r[conv_regs_pkg::BIT_SYNC_PH90] == $past(phase_cond.sync_input_phase90_status));
  endproperty
  a_late_status: assert property (p_late_status) else $error("late phase status stale"); // [RULE_11]

  property p_lost_sets;
    @(posedge sys_clk) disable iff (!resetn)
      (irq_en_r[5] && lock_cond.sync_lost && !soft_rst) |=> status_r[5];
  endproperty
  a_lost_sets: assert property (p_lost_sets) else $error("lost bit not set"); // [RULE_05]

  property p_mode_write;
    @(posedge sys_clk) disable iff (!resetn)
      s_write(conv_regs_pkg::ADDR_MODE_SEL) |=> (output_mode == $past(wr_data[1:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("output mode not stored"); // [RULE_09]

  property p_ctrl_enable_write;
    @(posedge sys_clk) disable iff (!resetn)
      s_write(conv_regs_pkg::ADDR_RX_CFG) |=>
        (ctrl_cfg.receiver_controller_enable == $past(wr_data[0]))
        && (ctrl_cfg.sync_controller_enable == $past(wr_data[4]));
  endproperty
  a_ctrl_enable_write: assert property (p_ctrl_enable_write) else $error("enable not stored"); // [RULE_20]

endmodule

// >>> hdl/conv_regs_pkg.sv
package conv_regs_pkg;

  // ************************************************
  // register addresses
  // ************************************************
  localparam logic [6:0] ADDR_PORT_CFG    = 7'h00;
  localparam logic [6:0] ADDR_IRQ_ENABLE  = 7'h03;
  localparam logic [6:0] ADDR_IRQ_STATUS  = 7'h04;
  localparam logic [6:0] ADDR_FS_LOW      = 7'h06;
  localparam logic [6:0] ADDR_FS_HIGH     = 7'h07;
  localparam logic [6:0] ADDR_MODE_SEL    = 7'h08;
  localparam logic [6:0] ADDR_CLK_PHASE   = 7'h0C;
  localparam logic [6:0] ADDR_SYNC_PHASE  = 7'h0D;
  localparam logic [6:0] ADDR_RX_CFG      = 7'h10;

  // ************************************************
  // field positions
  // ************************************************
  localparam int BIT_SOFT_RESET   = 5;
  localparam int BIT_SLEEP        = 7;
  localparam int BIT_EARLY_PH0    = 2;
  localparam int BIT_LATE_PH0     = 0;
  localparam int BIT_SYNC_PH90    = 5;
  localparam int BIT_SYNC_PH0     = 4;
  localparam int BIT_SYNC_FLG_CLR = 7;
  localparam int BIT_SYNC_LOOP    = 6;
  localparam int BIT_SYNC_ROLE    = 5;
  localparam int BIT_SYNC_ENA     = 4;
  localparam int BIT_RX_FLG_CLR   = 2;
  localparam int BIT_RX_LOOP      = 1;
  localparam int BIT_RX_ENA       = 0;

  // lost-type positions in the status word
  localparam logic [5:0] LOST_MASK = 6'h2A;

  // ************************************************
  // write and read masks
  // ************************************************
  localparam logic [7:0] WR_MASK_FS_HIGH = 8'h83;
  localparam logic [7:0] WR_MASK_RX_CFG  = 8'hF7;
  localparam logic [7:0] RD_MASK_RX_CFG  = 8'h7B;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] RST_PORT_CFG  = 8'h00;
  localparam logic [5:0] RST_IRQ_EN    = 6'h00;
  localparam logic [7:0] RST_FS_LOW    = 8'h00;
  localparam logic [7:0] RST_FS_HIGH   = 8'h02;
  localparam logic [1:0] RST_MODE      = 2'h0;
  localparam logic [7:0] RST_RX_CFG    = 8'h42;
  localparam logic [5:0] RST_STATUS    = 6'h00;
  localparam logic [7:0] RST_PHASE     = 8'h00;

  // ************************************************
  // serial frame: rw, 7-bit address, 8 data bits
  // ************************************************
  localparam logic [4:0] CNT_INSTR_LAST = 5'h07;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h0F;

  typedef enum logic [1:0] {
    MODE_BASEBAND = 2'h0,
    MODE_RTZ      = 2'h1,
    MODE_MIX      = 2'h2
  } output_mode_type;

  // bit order matches the enable and status registers, 5 down to 0
  typedef struct packed {
    logic sync_lost;
    logic sync_locked;
    logic phase_ctl_lost;
    logic phase_ctl_locked;
    logic receiver_lost;
    logic receiver_locked;
  } lock_cond_type;

  typedef struct packed {
    logic early_edge_phase0_status;
    logic late_edge_phase0_status;
    logic sync_input_phase90_status;
    logic sync_input_phase0_status;
  } phase_cond_type;

  typedef struct packed {
    logic sync_flag_clear;
    logic sync_auto_relock;
    logic sync_role_select;
    logic sync_controller_enable;
    logic receiver_flag_clear;
    logic receiver_auto_relock;
    logic receiver_controller_enable;
  } ctrl_cfg_type;

endpackage

// >>> verification/test_dac_ctrl_irq_status_regs.sv
module test_dac_ctrl_irq_status_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************
  // signals
  // ************************************************
  logic                            sys_clk  = 1'b0;
  logic                            resetn   = 1'b0;
  logic                            spi_cs_n = 1'b1;
  logic                            spi_sclk = 1'b0;
  logic                            spi_sdi  = 1'b0;
  logic                            spi_sdo;
  logic                            spi_sdo_oe;
  conv_regs_pkg::lock_cond_type    lock_cond  = '0;
  conv_regs_pkg::phase_cond_type   phase_cond = '0;
  logic [9:0]                      full_scale_code;
  logic                            sleep;
  conv_regs_pkg::output_mode_type  output_mode;
  conv_regs_pkg::ctrl_cfg_type     ctrl_cfg;
  logic                            irq;
  int                              err_total       = 0;
  int                              samples_checked = 0;

  always #20 sys_clk = ~sys_clk;

  dac_ctrl_irq_status_regs dut_u (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .spi_cs_n        (spi_cs_n),
    .spi_sclk        (spi_sclk),
    .spi_sdi         (spi_sdi),
    .spi_sdo         (spi_sdo),
    .spi_sdo_oe      (spi_sdo_oe),
    .lock_cond       (lock_cond),
    .phase_cond      (phase_cond),
    .full_scale_code (full_scale_code),
    .sleep           (sleep),
    .output_mode     (output_mode),
    .ctrl_cfg        (ctrl_cfg),
    .irq             (irq)
  );

  // ************************************************
  // helpers
  // ************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one frame: rw, 7-bit address, 8 data bits, msb first, 6 cycles per level
  task automatic spi_frame(input logic rd, input logic [6:0] addr,
                           input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] word;
    word = {rd, addr, wdat};
    rdat = 8'h00;
    spi_cs_n = 1'b0;
    cyc(4);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk = 1'b0;
      spi_sdi = word[i];
      cyc(6);
      if (i < 8) rdat[i] = spi_sdo;
      if (rd && i == 7) chk_val({15'h0, spi_sdo_oe}, 16'h0001);
      spi_sclk = 1'b1;
      cyc(6);
    end
    spi_sclk = 1'b0;
    spi_sdi = ~spi_sdi;
    cyc(6);
    spi_cs_n = 1'b1;
    cyc(4);
    if (rd) chk_val({15'h0, spi_sdo_oe}, 16'h0000);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    spi_frame(1'b0, addr, data, unused);
  endtask

  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] got;
    spi_frame(1'b1, addr, 8'h00, got);
    chk_val({8'h0, got & mask}, {8'h0, exp & mask});
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    $display("CHECK FAILED at %0t got %h exp %h", $time, 1'b0, 1'b1);
    close_out();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    cyc(10);
    resetn = 1'b1;
    cyc(2);
    chk_val({6'h0, full_scale_code}, 16'h0200);
    chk_val({15'h0, sleep}, 16'h0000);
    chk_val({14'h0, output_mode}, 16'h0000);
    chk_val({9'h0, ctrl_cfg}, 16'h0022);
    chk_val({15'h0, irq}, 16'h0000);
    rd_chk(conv_regs_pkg::ADDR_FS_LOW, 8'h00, 8'hFF);
    rd_chk(conv_regs_pkg::ADDR_FS_HIGH, 8'h02, 8'hFF);
    rd_chk(conv_regs_pkg::ADDR_MODE_SEL, 8'h00, 8'hFF);
    rd_chk(conv_regs_pkg::ADDR_RX_CFG, 8'h42, 8'hF7);
    rd_chk(conv_regs_pkg::ADDR_IRQ_ENABLE, 8'h00, 8'hFF);
    rd_chk(7'h7F, 8'h00, 8'hFF);
    lock_cond = 6'h3F;
    cyc(4);
    rd_chk(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h00, 8'hFF);
    chk_val({15'h0, irq}, 16'h0000);
    end_test("reset");

    wr(conv_regs_pkg::ADDR_FS_LOW, 8'hFF);
    wr(conv_regs_pkg::ADDR_FS_HIGH, 8'h83);
    chk_val({6'h0, full_scale_code}, 16'h03FF);
    chk_val({15'h0, sleep}, 16'h0001);
    rd_chk(conv_regs_pkg::ADDR_FS_HIGH, 8'h83, 8'h83);
    wr(conv_regs_pkg::ADDR_FS_HIGH, 8'h01);
    wr(conv_regs_pkg::ADDR_FS_LOW, 8'h00);
    chk_val({6'h0, full_scale_code}, 16'h0100);
    chk_val({15'h0, sleep}, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(conv_regs_pkg::ADDR_MODE_SEL, 8'(m));
      chk_val({14'h0, output_mode}, 16'(m));
      rd_chk(conv_regs_pkg::ADDR_MODE_SEL, 8'(m), 8'h03);
    end
    end_test("full_scale_mode");

    wr(conv_regs_pkg::ADDR_RX_CFG, 8'hFF);
    chk_val({9'h0, ctrl_cfg}, 16'h007F);
    rd_chk(conv_regs_pkg::ADDR_RX_CFG, 8'h73, 8'hF7);
    wr(conv_regs_pkg::ADDR_RX_CFG, 8'h00);
    chk_val({9'h0, ctrl_cfg}, 16'h0000);
    end_test("controller_cfg");

    wr(conv_regs_pkg::ADDR_IRQ_ENABLE, 8'h3F);
    cyc(4);
    rd_chk(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h3F, 8'hFF);
    chk_val({15'h0, irq}, 16'h0001);
    lock_cond = 6'h00;
    cyc(4);
    wr(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h00);
    rd_chk(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h2A, 8'hFF);
    chk_val({15'h0, irq}, 16'h0001);
    wr(conv_regs_pkg::ADDR_IRQ_ENABLE, 8'h00);
    rd_chk(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h00, 8'hFF);
    chk_val({15'h0, irq}, 16'h0000);
    wr(conv_regs_pkg::ADDR_IRQ_ENABLE, 8'h3F);
    lock_cond = 6'h15;
    cyc(4);
    rd_chk(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h15, 8'hFF);
    wr(conv_regs_pkg::ADDR_IRQ_ENABLE, 8'h01);
    rd_chk(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h01, 8'hFF);
    chk_val({15'h0, irq}, 16'h0001);
    end_test("status");

    phase_cond = 4'hA;
    cyc(4);
    rd_chk(conv_regs_pkg::ADDR_CLK_PHASE, 8'h04, 8'h05);
    rd_chk(conv_regs_pkg::ADDR_SYNC_PHASE, 8'h20, 8'h30);
    phase_cond = 4'h5;
    cyc(4);
    rd_chk(conv_regs_pkg::ADDR_CLK_PHASE, 8'h01, 8'h05);
    rd_chk(conv_regs_pkg::ADDR_SYNC_PHASE, 8'h10, 8'h30);
    end_test("phase");

    wr(conv_regs_pkg::ADDR_FS_LOW, 8'h55);
    wr(conv_regs_pkg::ADDR_PORT_CFG, 8'h20);
    chk_val({6'h0, full_scale_code}, 16'h0200);
    rd_chk(conv_regs_pkg::ADDR_IRQ_STATUS, 8'h00, 8'hFF);
    wr(conv_regs_pkg::ADDR_FS_LOW, 8'hAA);
    wr(conv_regs_pkg::ADDR_PORT_CFG, 8'h00);
    rd_chk(conv_regs_pkg::ADDR_FS_LOW, 8'h00, 8'hFF);
    wr(conv_regs_pkg::ADDR_FS_LOW, 8'h77);
    chk_val({6'h0, full_scale_code}, 16'h0277);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(2);
    chk_val({6'h0, full_scale_code}, 16'h0200);
    end_test("soft_reset");
    close_out();
  end
endmodule
